// >>> verilog/isa_pkg.sv
// Constants for the interrupt status aggregator: register map, field
// positions, counts and values after reset.
// Assumes an AHB-Lite slave decoding the low eight address bits.
package isa_pkg;
   // -----------------------------------------------------------------
   // Register map, byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] ML_BASE    = 8'h00; // Mapper latches, 6 words.
   localparam logic [7:0] ME_BASE    = 8'h20; // Mapper enables, 6 words.
   localparam logic [7:0] FS_BASE    = 8'h40; // Framer status, 9 words.
   localparam logic [7:0] FE_BASE    = 8'h80; // Framer enables, 9 words.
   localparam logic [7:0] FINFO_ADDR = 8'hC0; // Framer info flags.
   localparam logic [7:0] GCTRL_ADDR = 8'hF0; // global_control_one.
   localparam logic [7:0] GSUM_ADDR  = 8'hF4; // Group summaries.
   localparam logic [7:0] GEN_ADDR   = 8'hF8; // Group enables.
   localparam logic [7:0] GID_ADDR   = 8'hFC; // mapper_id_low/high.
   // -----------------------------------------------------------------
   // Counts and field positions
   // -----------------------------------------------------------------
   localparam int N_MAP = 6;  // Mapper latched registers.
   localparam int N_FR  = 9;  // Framer status registers.
   localparam int N_GRP = 5;  // Summary groups.
   localparam logic [2:0] N_MAP_IDX = 3'h6;
   localparam logic [3:0] N_FR_IDX  = 4'h9;
   localparam int CTRL_RST_BIT  = 0; // Mapper global software reset.
   localparam int CTRL_IDLE_BIT = 1; // irq_idle_drive_select.
   // Mapper latch indices.
   localparam int L_TXQ = 0; // txqueue_threshold_latch.
   localparam int L_TXP = 1; // tx_packet_latch.
   localparam int L_RXP = 2; // rx_packet_latch.
   localparam int L_LAP = 3; // rx_laps_latch.
   localparam int L_RXQ = 4; // rxqueue_threshold_latch.
   localparam int L_TST = 5; // tester_status_latch.
   // Summary group bits.
   localparam int G_LINE = 0; // line_group_summary.
   localparam int G_RXQ  = 1; // rxqueue_group_summary.
   localparam int G_TST  = 2; // tester_group_summary.
   localparam int G_PKT  = 3; // packet_group_summary.
   localparam int G_FR   = 4; // Framer information summary.
   // Sync loss and regain bits in framer_status_two.
   localparam int SYNC_REG  = 1;
   localparam int SYNC_LOSS = 0;
   localparam int SYNC_GAIN = 4;
   // -----------------------------------------------------------------
   // Values after reset
   // -----------------------------------------------------------------
   localparam logic [4:0] GEN_RST = 5'h00;
   localparam logic [7:0] EN_RST  = 8'h00;
endpackage

// >>> verilog/isa_top.sv
// Interrupt status aggregator: mapper latches, framer status polling,
// group summaries and the interrupt pin, behind an AHB-Lite slave.
// Assumes event inputs come from logic on hclk and need no sync.
//
// Contract
// - Global registers sit at 0F0h to 0FFh.
// - Four summary groups point to their latches.
// - Group summary is live, drops when serviced.
// - Writing one clears a mapper latch bit.
// - Latch forwards only while its enable is one.
// - Disabled latch bits still set for polling.
// - Control bit picks released or driven idle.
// - Reading a mapper latch clears the register.
// - No interrupt while any reset is active.
// - Zero group enable blocks that group.
// - Serviced latches clear summary and pin.
// - Nine framer info flags mark contributors.
// - Framer event bit sets, read clears it.
// - Framer condition bit stays while condition persists.
// - Framer write refreshes bits written one.
// - Sync loss bit 0, regain bit 4.
// - Double-interrupt bits set on both edges.
// - Software reset bit holds until zero written.
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module isa_top #(
   parameter logic [31:0] MAPPER_ID = 32'h0000_5A01, // Arbitrary value.
   parameter logic [71:0] DOUBLE_MASK = 72'h00_0000_0000_0000_0002
) (
   input  wire logic        hclk,      // System clock, 100 MHz.
   input  wire logic        hresetn,   // Asynchronous reset, active low.
   input  wire logic        hsel,      // Slave select.
   input  wire logic [7:0]  haddr,     // Byte address.
   input  wire logic [1:0]  htrans,    // Transfer type.
   input  wire logic        hwrite,    // Write when high.
   input  wire logic [2:0]  hsize,     // Transfer size, word only.
   input  wire logic [31:0] hwdata,    // Write data.
   input  wire logic        hready,    // Bus ready.
   output logic [31:0]      hrdata,    // Read data.
   output logic             hreadyout, // Slave ready.
   output logic             hresp,     // Always OKAY.
   input  wire logic [isa_pkg::N_MAP-1:0][7:0] latch_set,   // Pulses.
   input  wire logic [isa_pkg::N_FR-1:0][7:0]  framer_event, // Pulses.
   input  wire logic [isa_pkg::N_FR-1:0][7:0]  framer_cond,  // Levels.
   input  wire logic        rx_sync_loss, // Framer sync loss level.
   output logic             irq_n_out,    // Interrupt pin level.
   output logic             irq_oe_n      // Low while pin is driven.
);
   // -----------------------------------------------------------------
   // State and decode
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [isa_pkg::N_MAP-1:0][7:0] mlatch;
      logic [isa_pkg::N_MAP-1:0][7:0] men;
      logic [isa_pkg::N_FR-1:0][7:0]  flatch;
      logic [isa_pkg::N_FR-1:0][7:0]  fsnap;
      logic [isa_pkg::N_FR-1:0][7:0]  fen;
      logic [isa_pkg::N_FR-1:0][7:0]  fcond;
      logic [7:0]                     fmask;
      logic [3:0]                     fsel;
      logic                           sreset;
      logic                           idle;
      logic [isa_pkg::N_GRP-1:0]      genable;
      logic [isa_pkg::N_GRP-1:0]      summary;
      logic [isa_pkg::N_FR-1:0]       info;
      logic                           irq_n;
      logic                           irq_oe_n;
      logic                           wr_pend;
      logic [7:0]                     wr_addr;
      logic [31:0]                    rdata;
      logic                           ready;
   } isa_state_t;

   localparam logic [3:0] K_NONE = 4'h0, K_ML = 4'h1, K_ME = 4'h2,
      K_FS = 4'h3, K_FE = 4'h4, K_FI = 4'h5, K_GC = 4'h6, K_GS = 4'h7,
      K_GE = 4'h8, K_ID = 4'h9;

   isa_state_t s_reg;
   isa_state_t s_next;
   logic       take;
   logic       irq_on;

   // Classifies a byte address into a register kind.
   function automatic logic [3:0] kind(input logic [7:0] a);
      logic [3:0] k;
      k = K_NONE;
      if (a[1:0] != 2'b00) begin
         k = K_NONE;
      end else if (a[7:5] == isa_pkg::ML_BASE[7:5] &&
                   a[4:2] < isa_pkg::N_MAP_IDX) begin
         k = K_ML;
      end else if (a[7:5] == isa_pkg::ME_BASE[7:5] &&
                   a[4:2] < isa_pkg::N_MAP_IDX) begin
         k = K_ME;
      end else if (a[7:6] == isa_pkg::FS_BASE[7:6] &&
                   a[5:2] < isa_pkg::N_FR_IDX) begin
         k = K_FS;
      end else if (a[7:6] == isa_pkg::FE_BASE[7:6] &&
                   a[5:2] < isa_pkg::N_FR_IDX) begin
         k = K_FE;
      end else if (a == isa_pkg::FINFO_ADDR) begin
         k = K_FI;
      end else if (a == isa_pkg::GCTRL_ADDR) begin
         k = K_GC;
      end else if (a == isa_pkg::GSUM_ADDR) begin
         k = K_GS;
      end else if (a == isa_pkg::GEN_ADDR) begin
         k = K_GE;
      end else if (a == isa_pkg::GID_ADDR) begin
         k = K_ID;
      end
      return k;
   endfunction

   // Value after reset; the idle pin is released, not driven.
   function automatic isa_state_t reset_value();
      isa_state_t v;
      v          = '0;
      v.genable  = isa_pkg::GEN_RST;
      v.irq_oe_n = 1'b1;
      v.ready    = 1'b1;
      return v;
   endfunction
   // A constant, so the asynchronous reset branch loads no logic.
   localparam isa_state_t rst_val = reset_value();

   assign take = hsel & htrans[1] & hready;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   // Order: the pending write, then the read, then hardware sets, so
   // a read right after a mask write sees the refreshed snapshot and
   // an event in the cycle of a clear is kept.
   always_comb begin
      logic [2:0]  mi;
      logic [3:0]  fi;
      logic [7:0]  wd;
      logic [31:0] rd;
      logic [isa_pkg::N_FR-1:0][7:0] cond;
      logic [isa_pkg::N_FR-1:0][7:0] ev;
      mi     = s_reg.wr_addr[4:2];
      fi     = s_reg.wr_addr[5:2];
      wd     = hwdata[7:0];
      rd     = 32'h0000_0000;
      cond   = framer_cond;
      ev     = framer_event;
      s_next = s_reg;
      // Write data phase.
      if (s_reg.wr_pend) begin
         case (kind(s_reg.wr_addr))
            K_ML: s_next.mlatch[mi] = s_reg.mlatch[mi] & ~wd;
            K_ME: s_next.men[mi] = wd;
            K_FS: begin
               s_next.fsnap[fi] = (wd & s_reg.flatch[fi]) |
                                  (~wd & s_reg.fsnap[fi]);
               s_next.fmask = wd;
               s_next.fsel  = fi;
            end
            K_FE: s_next.fen[fi] = wd;
            K_GC: begin
               s_next.sreset = hwdata[isa_pkg::CTRL_RST_BIT];
               s_next.idle   = hwdata[isa_pkg::CTRL_IDLE_BIT];
            end
            K_GE: s_next.genable = hwdata[isa_pkg::N_GRP-1:0];
            default: ;
         endcase
      end
      s_next.wr_pend = take & hwrite;
      s_next.wr_addr = take ? haddr : s_reg.wr_addr;
      // Read address phase, data registered for the data phase.
      mi = haddr[4:2];
      fi = haddr[5:2];
      if (take && !hwrite) begin
         case (kind(haddr))
            K_ML: begin
               rd[7:0] = s_next.mlatch[mi];
               s_next.mlatch[mi] = 8'h00;
            end
            K_ME: rd[7:0] = s_next.men[mi];
            K_FS: begin
               rd[7:0] = s_next.fsnap[fi];
               // The mask written just before selects what is cleared.
               if (s_next.fsel == fi) begin
                  s_next.flatch[fi] = s_next.flatch[fi] &
                                      ~s_next.fmask;
               end
               s_next.fmask = 8'h00;
            end
            K_FE: rd[7:0] = s_next.fen[fi];
            K_FI: rd[isa_pkg::N_FR-1:0] = s_reg.info;
            K_GC: begin
               rd[isa_pkg::CTRL_RST_BIT]  = s_next.sreset;
               rd[isa_pkg::CTRL_IDLE_BIT] = s_next.idle;
            end
            K_GS: rd[isa_pkg::N_GRP-1:0] = s_reg.summary;
            K_GE: rd[isa_pkg::N_GRP-1:0] = s_next.genable;
            K_ID: rd = MAPPER_ID;
            default: rd = 32'h0000_0000;
         endcase
      end
      s_next.rdata = rd;
      // Hardware sets win over every clear above.
      s_next.mlatch = s_next.mlatch | latch_set;
      cond[isa_pkg::SYNC_REG][isa_pkg::SYNC_LOSS] = rx_sync_loss;
      ev[isa_pkg::SYNC_REG][isa_pkg::SYNC_GAIN] =
         framer_event[isa_pkg::SYNC_REG][isa_pkg::SYNC_GAIN] |
         (s_reg.fcond[isa_pkg::SYNC_REG][isa_pkg::SYNC_LOSS] &
          ~rx_sync_loss);
      // Condition bits re-set while present; double bits also on fall.
      s_next.flatch = s_next.flatch | ev | cond |
                      (DOUBLE_MASK & s_reg.fcond & ~cond);
      s_next.fcond = cond;
      // Summaries and info flags follow the enabled latches live.
      for (int i = 0; i < isa_pkg::N_FR; i++) begin
         s_next.info[i] = |(s_reg.flatch[i] & s_reg.fen[i]);
      end
      s_next.summary[isa_pkg::G_LINE] =
         |(s_reg.mlatch[isa_pkg::L_TXQ] & s_reg.men[isa_pkg::L_TXQ]) |
         |(s_reg.mlatch[isa_pkg::L_TXP] & s_reg.men[isa_pkg::L_TXP]) |
         |(s_reg.mlatch[isa_pkg::L_RXP] & s_reg.men[isa_pkg::L_RXP]) |
         |(s_reg.mlatch[isa_pkg::L_LAP] & s_reg.men[isa_pkg::L_LAP]);
      s_next.summary[isa_pkg::G_RXQ] =
         |(s_reg.mlatch[isa_pkg::L_RXQ] & s_reg.men[isa_pkg::L_RXQ]);
      s_next.summary[isa_pkg::G_TST] =
         |(s_reg.mlatch[isa_pkg::L_TST] & s_reg.men[isa_pkg::L_TST]);
      s_next.summary[isa_pkg::G_PKT] =
         |(s_reg.mlatch[isa_pkg::L_TXP] & s_reg.men[isa_pkg::L_TXP]) |
         |(s_reg.mlatch[isa_pkg::L_RXP] & s_reg.men[isa_pkg::L_RXP]);
      s_next.summary[isa_pkg::G_FR] = |s_reg.info;
      // Pin: asserted is low and driven; idle per the select bit.
      s_next.irq_oe_n = s_reg.idle ? 1'b0 : ~irq_on;
      s_next.irq_n    = s_reg.idle ? ~irq_on : 1'b0;
      s_next.ready    = 1'b1;
      // Software reset clears all but itself and the bus pipeline.
      if (s_next.sreset) begin
         s_next         = rst_val;
         s_next.sreset  = 1'b1;
         s_next.wr_pend = take & hwrite;
         s_next.wr_addr = take ? haddr : s_reg.wr_addr;
         s_next.rdata   = rd;
      end
   end

   // Enabled summaries raise the pin unless a reset is active.
   assign irq_on = ~s_reg.sreset &
                   |(s_reg.summary & s_reg.genable);

   // -----------------------------------------------------------------
   // State register and outputs
   // -----------------------------------------------------------------
   // Registers the whole state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= rst_val;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hrdata    = s_reg.rdata;
   assign hreadyout = s_reg.ready;
   assign hresp     = 1'b0;
   assign irq_n_out = s_reg.irq_n;
   assign irq_oe_n  = s_reg.irq_oe_n;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   logic pin_on;
   assign pin_on = !irq_oe_n && !irq_n_out;

   // Levels due one cycle on; a software reset being set forces idle.
   logic pin_due;
   logic idle_drive;
   logic tst_live;
   assign pin_due    = irq_on && !s_next.sreset;
   assign idle_drive = s_reg.idle && !s_next.sreset;
   assign tst_live   = !s_next.sreset &&
      |(s_reg.mlatch[isa_pkg::L_TST] & s_reg.men[isa_pkg::L_TST]);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   w1c_clear_a: assert property (
      s_reg.wr_pend && s_reg.wr_addr == isa_pkg::ML_BASE && hwdata[0] &&
      !latch_set[0][0] && !s_next.sreset |=> !s_reg.mlatch[0][0])
      else $error("mapper latch bit not cleared by write one");
   rd_clear_a: assert property (
      take && !hwrite && haddr == isa_pkg::ML_BASE && !s_reg.wr_pend &&
      latch_set[0] == 8'h00 |=> s_reg.mlatch[0] == 8'h00)
      else $error("mapper latch not cleared by read");
   poll_set_a: assert property (
      latch_set[isa_pkg::L_TST][0] && !s_next.sreset
      |=> s_reg.mlatch[isa_pkg::L_TST][0])
      else $error("latch bit lost its event");
   live_sum_a: assert property (
      ##1 s_reg.summary[isa_pkg::G_TST] == $past(tst_live))
      else $error("tester summary not live");
   pin_gate_a: assert property (
      ##2 pin_on == $past(pin_due, 1))
      else $error("pin does not follow enabled summaries");
   rst_quiet_a: assert property (
      s_reg.sreset [*2] |-> !pin_on)
      else $error("interrupt during software reset");
   idle_mode_a: assert property (
      ##1 !pin_on |-> ($past(idle_drive) ? !irq_oe_n : irq_oe_n))
      else $error("idle pin drive wrong");
   cond_hold_a: assert property (
      framer_cond[0][0] && !s_next.sreset |=> s_reg.flatch[0][0])
      else $error("condition bit dropped while present");
   snap_hold_a: assert property (
      s_reg.wr_pend && s_reg.wr_addr == isa_pkg::FS_BASE && !hwdata[0] &&
      !s_next.sreset |=> $stable(s_reg.fsnap[0][0]))
      else $error("unselected snapshot bit changed");
   regain_a: assert property (
      s_reg.fcond[isa_pkg::SYNC_REG][isa_pkg::SYNC_LOSS] && !rx_sync_loss
      && !s_next.sreset
      |=> s_reg.flatch[isa_pkg::SYNC_REG][isa_pkg::SYNC_GAIN])
      else $error("sync regain event missed");
endmodule

// >>> tb/isa_pin_model.sv
// Far side of the interrupt pin: a board pull-up and the host input.
// Assumes the pin is released while irq_oe_n is high.
`timescale 1ns/100ps
module isa_pin_model (
   input  wire logic irq_n_out, // Level driven by the block.
   input  wire logic irq_oe_n,  // Low while the block drives.
   output logic      irq_pin    // Level the host sees.
);
   // The pull-up wins whenever the driver is off.
   assign irq_pin = irq_oe_n ? 1'b1 : irq_n_out;
endmodule

// >>> tb/isa_top_tb.sv
// Register-level bench for the interrupt status aggregator.
// Assumes a zero-wait AHB-Lite slave and a pulled-up interrupt pin.
`timescale 1ns/100ps
module isa_top_tb;
   logic                          hclk, hresetn, hsel, hwrite;
   logic [7:0]                    haddr;
   logic [1:0]                    htrans;
   logic [2:0]                    hsize;
   logic [31:0]                   hwdata, hrdata, r;
   logic                          hreadyout, hresp, irq_n_out, irq_oe_n;
   logic                          irq_pin, rx_sync_loss;
   logic [isa_pkg::N_MAP-1:0][7:0] latch_set;
   logic [isa_pkg::N_FR-1:0][7:0]  framer_event, framer_cond;
   int                            n_errors, num_checks;
   // -----------------------------------------------------------------
   // Instances
   // -----------------------------------------------------------------
   isa_top isa_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .latch_set(latch_set),
      .framer_event(framer_event), .framer_cond(framer_cond),
      .rx_sync_loss(rx_sync_loss), .irq_n_out(irq_n_out),
      .irq_oe_n(irq_oe_n));
   isa_pin_model isa_pin_model_i (.irq_n_out(irq_n_out),
      .irq_oe_n(irq_oe_n), .irq_pin(irq_pin));
   // -----------------------------------------------------------------
   // Clock, watchdog and helpers
   // -----------------------------------------------------------------
   // The clock toggles every half period of 10 ns.
   always #5 hclk = ~hclk;
   // The tests take under 200 cycles; this cuts a hang short.
   initial begin
      #50000;
      n_errors++;
      final_report();
   end
   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One single AHB-Lite transfer; read data is taken at the end.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // Reads a register and compares it with the expected value.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(r, exp);
   endtask
   // Raises a one-cycle pulse on a mapper latch input.
   task automatic mpulse(input int i, input logic [7:0] v);
      @(posedge hclk);
      latch_set[i] <= v;
      @(posedge hclk);
      latch_set[i] <= 8'h00;
   endtask
   // Raises a one-cycle pulse on a framer event input.
   task automatic fpulse(input int i, input logic [7:0] v);
      @(posedge hclk);
      framer_event[i] <= v;
      @(posedge hclk);
      framer_event[i] <= 8'h00;
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   // Inputs start quiet, reset is held, then the scenarios run in turn.
   initial begin
      hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0;
      haddr = 8'h00; htrans = 2'h0; hsize = 3'h2; hwdata = 32'h0;
      latch_set = '0; framer_event = '0; framer_cond = '0;
      rx_sync_loss = 1'b0; n_errors = 0; num_checks = 0;
      repeat (12) @(posedge hclk);
      check({31'h0, irq_pin}, 32'h1);
      check({31'h0, hreadyout}, 32'h1);
      hresetn <= 1'b1;
      check({31'h0, hresp}, 32'h0);
      rd(isa_pkg::GEN_ADDR, 32'h0000_0000);
      rd(isa_pkg::GID_ADDR, 32'h0000_5A01);
      bus(1'b1, isa_pkg::GCTRL_ADDR, 32'h0000_0000);
      bus(1'b1, 8'hE0, 32'h0000_00FF);
      rd(8'hE0, 32'h0000_0000);
      // Disabled latch bits still set and are cleared by a read.
      mpulse(0, 8'h05);
      rd(8'h00, 32'h0000_0005);
      mpulse(isa_pkg::L_TST, 8'h01);
      rd(8'h14, 32'h0000_0001);
      rd(8'h00, 32'h0000_0000);
      // Enabled bit reaches the pin; write-one clears only that bit.
      bus(1'b1, 8'h20, 32'h0000_0001);
      bus(1'b1, isa_pkg::GEN_ADDR, 32'h0000_001F);
      mpulse(0, 8'h03);
      repeat (3) @(posedge hclk);
      check({31'h0, irq_pin}, 32'h0);
      rd(isa_pkg::GSUM_ADDR, 32'h0000_0001);
      bus(1'b1, 8'h00, 32'h0000_0001);
      rd(isa_pkg::GSUM_ADDR, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      check({31'h0, irq_pin}, 32'h1);
      rd(8'h00, 32'h0000_0002);
      rd(8'h00, 32'h0000_0000);
      // A zero group enable keeps the pin idle though the summary is up.
      bus(1'b1, isa_pkg::GEN_ADDR, 32'h0000_0000);
      mpulse(0, 8'h01);
      repeat (3) @(posedge hclk);
      rd(isa_pkg::GSUM_ADDR, 32'h0000_0001);
      check({31'h0, irq_pin}, 32'h1);
      rd(8'h00, 32'h0000_0001);
      // Driven idle level, then the software reset holds and clears.
      bus(1'b1, isa_pkg::GCTRL_ADDR, 32'h0000_0002);
      repeat (2) @(posedge hclk);
      check({30'h0, irq_oe_n, irq_n_out}, 32'h1);
      bus(1'b1, isa_pkg::GEN_ADDR, 32'h0000_001F);
      bus(1'b1, isa_pkg::GCTRL_ADDR, 32'h0000_0001);
      rd(isa_pkg::GCTRL_ADDR, 32'h0000_0001);
      mpulse(0, 8'h01);
      repeat (3) @(posedge hclk);
      check({31'h0, irq_pin}, 32'h1);
      rd(isa_pkg::GEN_ADDR, 32'h0000_0000);
      bus(1'b1, isa_pkg::GCTRL_ADDR, 32'h0000_0000);
      rd(isa_pkg::GCTRL_ADDR, 32'h0000_0000);
      // Framer event: mask write then read; a read clears the event.
      fpulse(2, 8'h08);
      bus(1'b1, 8'h48, 32'h0000_0008);
      rd(8'h48, 32'h0000_0008);
      bus(1'b1, 8'h48, 32'h0000_0008);
      rd(8'h48, 32'h0000_0000);
      fpulse(2, 8'h08);
      bus(1'b1, 8'h48, 32'h0000_0000);
      rd(8'h48, 32'h0000_0000);
      bus(1'b1, 8'h48, 32'h0000_0008);
      rd(8'h48, 32'h0000_0008);
      // A condition bit survives reads while the condition lasts.
      framer_cond[3] <= 8'h01;
      framer_cond[0] <= 8'h01;
      repeat (2) @(posedge hclk);
      bus(1'b1, 8'h4C, 32'h0000_0001);
      rd(8'h4C, 32'h0000_0001);
      bus(1'b1, 8'h4C, 32'h0000_0001);
      rd(8'h4C, 32'h0000_0001);
      bus(1'b1, 8'h40, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000);
      // Info flag names the framer register that contributes.
      bus(1'b1, 8'h88, 32'h0000_0008);
      fpulse(2, 8'h08);
      repeat (2) @(posedge hclk);
      rd(isa_pkg::FINFO_ADDR, 32'h0000_0004);
      // Sync loss sets bit 0; regaining sync sets bit 4.
      rx_sync_loss <= 1'b1;
      repeat (2) @(posedge hclk);
      bus(1'b1, 8'h44, 32'h0000_0011);
      rd(8'h44, 32'h0000_0001);
      rx_sync_loss <= 1'b0;
      repeat (3) @(posedge hclk);
      bus(1'b1, 8'h44, 32'h0000_0011);
      check(r & 32'h10, 32'h0);
      rd(8'h44, 32'h0000_0011);
      final_report();
   end
endmodule
